// ===== hdl/dsdm_defines.vh
// constants for the dual switch diagnostic mux and mode logic
`ifndef DSDM_DEFINES_VH
`define DSDM_DEFINES_VH

// mode codes reported on mode_o
`define DSDM_MODE_STBY_DLY 3'h0
`define DSDM_MODE_STANDBY  3'h1
`define DSDM_MODE_DIAG     3'h2
`define DSDM_MODE_ACTIVE   3'h3
`define DSDM_MODE_FAULT    3'h4

// per-channel states
`define DSDM_CH_OFF        2'h0
`define DSDM_CH_ON         2'h1
`define DSDM_CH_FAULT      2'h2
`define DSDM_CH_RETRY      2'h3

// sense mux codes on sense_kind_o
`define DSDM_SNS_CH1       3'h0
`define DSDM_SNS_CH2       3'h1
`define DSDM_SNS_TEMP      3'h2
`define DSDM_SNS_FAULT     3'h3
`define DSDM_SNS_NONE      3'h4

// timing, in microseconds, and clock rate in MHz
`define DSDM_CLK_MHZ       25
`define DSDM_STBY_US       1000
`define DSDM_RETRY_US      2000
`define DSDM_STBY_CYC      (`DSDM_STBY_US * `DSDM_CLK_MHZ)
`define DSDM_RETRY_CYC     (`DSDM_RETRY_US * `DSDM_CLK_MHZ)

`endif

// ===== hdl/dsdm_switch_ctrl.v
// control, mode machine and sense multiplexer of a dual high-side switch
//
// Contract
// - shutdown, open-load and short faults show as fault level on sense.
// - open-load and short never flagged while that channel is on.
// - a channel fault shows on sense only while that channel is selected.
// - temperature selection reports the hotter channel.
// - two-select mux: off, ch1, ch2, temperature; fault replaces currents.
// - fault detected during retry wait or open-load/short condition.
// - fault pin asserts only for its own channel's faults.
// - fault-pin variant: diag off releases all; fault pulls pin low.
// - all inputs low enters standby delay, then standby after delay.
// - standby gives no diagnostics and lowest power.
// - diagnostic state runs diagnostics with both switches off.
// - active whenever a switch is enabled and no channel is in fault; diagnostics independent.
// - thermal or current-limit shutdown puts the channel in fault.
// - leave fault only when cleared, latch low and retry timer expired.
// - after fault, channel turns on only if its enable is high.
// - channels operate and fault independently.
// - off-state open-load gated; cleared on diag fall or enable rise.
// - after retry, hold fault indication until output near supply.
`timescale 1ns/100ps
`default_nettype none
`include "dsdm_defines.vh"

module dsdm_switch_ctrl
#(
   parameter FAULT_PIN_VARIANT = 0,
   parameter STBY_CYCLES       = `DSDM_STBY_CYC,
   parameter RETRY_CYCLES      = `DSDM_RETRY_CYC,
   parameter CNT_W             = 24
)
(
   input  wire       clk_i,
   input  wire       reset_i,
   input  wire       ch1_switch_on_i,
   input  wire       ch2_switch_on_i,
   input  wire       diag_enable_i,
   input  wire       sense_kind_select_i,
   input  wire       sense_channel_select_i,
   input  wire       latch_i,
   input  wire [1:0] overtemp_i,
   input  wire [1:0] overcurrent_i,
   input  wire [1:0] openload_i,
   input  wire [1:0] out_near_supply_i,
   input  wire       ch1_hotter_i,
   output wire [1:0] gate_on_o,
   output wire [2:0] mode_o,
   output wire [2:0] sense_kind_o,
   output wire       sense_out_oe_o,
   output wire       fault_sense_level_o,
   output wire       temp_from_ch2_o,
   output wire [1:0] channel_fault_out_o,
   output wire [1:0] channel_fault_out_oe_o,
   output wire [1:0] fault_detect_o
);

   // *********************************************************
   // input synchronisers
   // *********************************************************
   reg  [4:0] meta_q;
   reg  [4:0] sync_q;
   reg  [4:0] sync_old_q;
   wire [4:0] raw_in;

   assign raw_in = {sense_channel_select_i, sense_kind_select_i,
                    diag_enable_i, ch2_switch_on_i, ch1_switch_on_i};

   // two flops per input, plus a delayed copy for edges
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         meta_q     <= 5'h00;
         sync_q     <= 5'h00;
         sync_old_q <= 5'h00;
      end
      else
      begin
         meta_q     <= raw_in;
         sync_q     <= meta_q;
         sync_old_q <= sync_q;
      end
   end

   wire [1:0] en_s    = sync_q[1:0];
   wire       diag_s  = sync_q[2];
   wire       kind_s  = sync_q[3];
   wire       chan_s  = sync_q[4];
   wire [1:0] en_rise = sync_q[1:0] & ~sync_old_q[1:0];
   wire       diag_fall = sync_old_q[2] & ~sync_q[2];

   // *********************************************************
   // standby delay counter
   // *********************************************************
   reg  [CNT_W-1:0] stby_cnt_q;
   reg              standby_q;
   wire             any_in = |en_s | diag_s;

   // restart whenever any enable or diag is high
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         stby_cnt_q <= {CNT_W{1'b0}};
         standby_q  <= 1'b0;
      end
      else if (any_in)
      begin
         stby_cnt_q <= {CNT_W{1'b0}};
         standby_q  <= 1'b0;
      end
      else if (stby_cnt_q == STBY_CYCLES[CNT_W-1:0] - 1'b1)
         standby_q  <= 1'b1;
      else
         stby_cnt_q <= stby_cnt_q + 1'b1;
   end

   // *********************************************************
   // per-channel state machines
   // *********************************************************
   // each channel owns its state and open-load flag inside the loop;
   // these flat copies let the mode logic read both channels
   wire [3:0] ch_state;                                 // ch1 in low pair
   wire [1:0] ol_flag;
   wire [1:0] shut_req = overtemp_i | overcurrent_i;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_ch
         reg [CNT_W-1:0] retry_cnt_q;
         reg [1:0]       ch_state_q;
         reg             ol_flag_q;
         wire            retry_done;

         // retry wait is over once the counter reaches its limit
         assign retry_done = (retry_cnt_q == RETRY_CYCLES[CNT_W-1:0]);

         // channel sequence, independent of the other channel
         always @(posedge clk_i or posedge reset_i)
         begin
            if (reset_i)
            begin
               ch_state_q  <= `DSDM_CH_OFF;
               retry_cnt_q <= {CNT_W{1'b0}};
            end
            else
            begin
               case (ch_state_q)
                  `DSDM_CH_OFF:
                     if (en_s[g])
                        ch_state_q <= `DSDM_CH_ON;
                  `DSDM_CH_ON:
                     if (shut_req[g])
                     begin
                        ch_state_q  <= `DSDM_CH_FAULT;
                        retry_cnt_q <= {CNT_W{1'b0}};
                     end
                     else if (!en_s[g])
                        ch_state_q <= `DSDM_CH_OFF;
                  `DSDM_CH_FAULT:
                  begin
                     if (!retry_done)
                        retry_cnt_q <= retry_cnt_q + 1'b1;
                     if (retry_done && !shut_req[g] && !latch_i)
                        ch_state_q <= en_s[g] ?
                           `DSDM_CH_RETRY : `DSDM_CH_OFF;
                  end
                  `DSDM_CH_RETRY:
                     if (shut_req[g])
                     begin
                        ch_state_q  <= `DSDM_CH_FAULT;
                        retry_cnt_q <= {CNT_W{1'b0}};
                     end
                     else if (!en_s[g])
                        ch_state_q <= `DSDM_CH_OFF;
                     else if (out_near_supply_i[g])
                        ch_state_q <= `DSDM_CH_ON;
                  default:
                     ch_state_q <= `DSDM_CH_OFF;
               endcase
            end
         end

         // off-state open-load flag follows the comparator while allowed;
         // the clearing edges win over a comparator that is still high
         always @(posedge clk_i or posedge reset_i)
         begin
            if (reset_i)
               ol_flag_q <= 1'b0;
            else if (diag_fall || en_rise[g])
               ol_flag_q <= 1'b0;
            else if (diag_s && !en_s[g] &&
                     ch_state_q == `DSDM_CH_OFF)
               ol_flag_q <= openload_i[g];
            else
               ol_flag_q <= 1'b0;
         end

         // export this channel's state for the mode logic
         assign ch_state[2*g+1:2*g] = ch_state_q;
         assign ol_flag[g]          = ol_flag_q;

         assign gate_on_o[g] = (ch_state_q == `DSDM_CH_ON) ||
                               (ch_state_q == `DSDM_CH_RETRY);
         // shutdown, retry ramp and open load all count as faults
         assign fault_detect_o[g] =
            (ch_state_q == `DSDM_CH_FAULT) ||
            (ch_state_q == `DSDM_CH_RETRY) ||
            ol_flag_q;
      end
   endgenerate

   // *********************************************************
   // device mode
   // *********************************************************
   reg [2:0] mode_q;

   // summary mode for the controller
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         mode_q <= `DSDM_MODE_STBY_DLY;
      else if (ch_state[1:0] == `DSDM_CH_FAULT ||
               ch_state[3:2] == `DSDM_CH_FAULT)
         mode_q <= `DSDM_MODE_FAULT;
      else if (|en_s)
         mode_q <= `DSDM_MODE_ACTIVE;
      else if (diag_s)
         mode_q <= `DSDM_MODE_DIAG;
      else if (standby_q)
         mode_q <= `DSDM_MODE_STANDBY;
      else
         mode_q <= `DSDM_MODE_STBY_DLY;
   end
   assign mode_o = mode_q;

   // *********************************************************
   // sense and fault pin multiplexer
   // *********************************************************
   reg  [2:0] kind_d;
   reg  [2:0] kind_q;
   reg  [1:0] flt_d;
   reg  [1:0] flt_q;
   reg        temp2_q;
   wire       diag_live = diag_s && !standby_q;
   wire       sel_fault = chan_s ? fault_detect_o[1] : fault_detect_o[0];

   // choose what the sense output carries
   always @*
   begin
      kind_d = `DSDM_SNS_NONE;
      flt_d  = 2'h0;
      if (diag_live)
      begin
         if (FAULT_PIN_VARIANT != 0)
         begin
            flt_d = fault_detect_o;
            if (sel_fault)
               kind_d = `DSDM_SNS_FAULT;
            else
               kind_d = chan_s ? `DSDM_SNS_CH2 : `DSDM_SNS_CH1;
         end
         else if (kind_s)
            kind_d = chan_s ? `DSDM_SNS_NONE : `DSDM_SNS_TEMP;
         else if (sel_fault)
            kind_d = `DSDM_SNS_FAULT;
         else
            kind_d = chan_s ? `DSDM_SNS_CH2 : `DSDM_SNS_CH1;
      end
   end

   // registered mux outputs
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         kind_q  <= `DSDM_SNS_NONE;
         flt_q   <= 2'h0;
         temp2_q <= 1'b0;
      end
      else
      begin
         kind_q  <= kind_d;
         flt_q   <= flt_d;
         temp2_q <= ~ch1_hotter_i;
      end
   end

   assign sense_kind_o           = kind_q;
   assign sense_out_oe_o         = (kind_q != `DSDM_SNS_NONE);
   assign fault_sense_level_o    = (kind_q == `DSDM_SNS_FAULT);
   assign temp_from_ch2_o        = temp2_q;
   assign channel_fault_out_o    = 2'h0;                // open drain pulls low
   assign channel_fault_out_oe_o = flt_q;

endmodule
`default_nettype wire

// ===== verification/dsdm_mcu_model.sv
// controller model that drives the switch control pins
`timescale 1ns/100ps
`default_nettype none
module dsdm_mcu_model
#(
   parameter FAULT_PIN_VARIANT = 0
)
(
   input  wire logic       clk_i,
   input  wire logic [4:0] cmd_i,
   output var  logic [4:0] pins_o
);
   // pins move only on the falling edge; kind select low on fault-pin parts
   initial pins_o = 5'h00;
   always @(negedge clk_i)
      pins_o <= (FAULT_PIN_VARIANT != 0) ? (cmd_i & 5'h1d) : cmd_i;
endmodule
`default_nettype wire

// ===== verification/dsdm_chk_assertions.sv
// assertions on the switch control outputs
`timescale 1ns/100ps
`default_nettype none
module dsdm_chk
(
   input wire logic       clk_i,
   input wire logic       reset_i,
   input wire logic       diag_enable_i,
   input wire logic       latch_i,
   input wire logic [1:0] overcurrent_i,
   input wire logic [1:0] gate_on_o,
   input wire logic [2:0] mode_o,
   input wire logic [2:0] sense_kind_o,
   input wire logic       sense_out_oe_o,
   input wire logic [1:0] fault_detect_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   property p_oe; sense_out_oe_o == (sense_kind_o != 3'h4); endproperty
   a_oe: assert property (p_oe) else $error("sense enable wrong");
   property p_hiz; !diag_enable_i [*5] |-> !sense_out_oe_o; endproperty
   a_hiz: assert property (p_hiz) else $error("sense driven");
   property p_shut;
      gate_on_o[0] && overcurrent_i[0] |=> !gate_on_o[0] && fault_detect_o[0];
   endproperty
   a_shut: assert property (p_shut) else $error("no shutdown");
   property p_latch;
      fault_detect_o[0] && !gate_on_o[0] && latch_i && mode_o == 3'h4
      |=> !gate_on_o[0];
   endproperty
   a_latch: assert property (p_latch) else $error("latch ignored");
   property p_retry;
      $fell(gate_on_o[0]) && fault_detect_o[0] |=> !gate_on_o[0] [*8];
   endproperty
   a_retry: assert property (p_retry) else $error("early retry");
   property p_stby; mode_o == 3'h1 |-> !sense_out_oe_o; endproperty
   a_stby: assert property (p_stby) else $error("standby sense");
   property p_enter;
      $changed(mode_o) && mode_o == 3'h1 |-> $past(mode_o) == 3'h0;
   endproperty
   a_enter: assert property (p_enter) else $error("standby entry");
   property p_act;
      gate_on_o != 2'h0 && $past(gate_on_o) != 2'h0
      |-> mode_o == 3'h3 || mode_o == 3'h4;
   endproperty
   a_act: assert property (p_act) else $error("not active");
endmodule
bind dsdm_switch_ctrl dsdm_chk chk_u (.clk_i(clk_i), .reset_i(reset_i),
   .diag_enable_i(diag_enable_i), .latch_i(latch_i),
   .overcurrent_i(overcurrent_i), .gate_on_o(gate_on_o), .mode_o(mode_o),
   .sense_kind_o(sense_kind_o), .sense_out_oe_o(sense_out_oe_o),
   .fault_detect_o(fault_detect_o));
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the dual switch control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [4:0]  cmd = 5'h00;
   logic        latch = 1'b0;
   logic        hot1 = 1'b0;
   logic [1:0]  ot = 2'h0, oc = 2'h0, ol = 2'h0, ns = 2'h0;
   logic [31:0] r;
   wire  [4:0]  pins;
   wire  [1:0]  gate, fdet;
   wire  [2:0]  mode, kind;
   wire         oe, fsl, t2;
   wire  [4:0]  pins_f;
   wire  [1:0]  fpin_f, fpin_oe_f;
   wire  [2:0]  kind_f;
   logic [2:0]  k0, k1;
   integer      num_errors = 0;
   integer      compares = 0;
   integer      seed = 11;
   integer      i;
   always #20 clk_i = ~clk_i;
   dsdm_mcu_model mcu_u (.clk_i(clk_i), .cmd_i(cmd), .pins_o(pins));
   dsdm_switch_ctrl #(.STBY_CYCLES(8), .RETRY_CYCLES(16)) dut_u (
      .clk_i(clk_i), .reset_i(reset_i), .ch1_switch_on_i(pins[4]),
      .ch2_switch_on_i(pins[3]), .diag_enable_i(pins[2]),
      .sense_kind_select_i(pins[1]), .sense_channel_select_i(pins[0]),
      .latch_i(latch), .overtemp_i(ot), .overcurrent_i(oc),
      .openload_i(ol), .out_near_supply_i(ns), .ch1_hotter_i(hot1),
      .gate_on_o(gate), .mode_o(mode), .sense_kind_o(kind),
      .sense_out_oe_o(oe), .fault_sense_level_o(fsl),
      .temp_from_ch2_o(t2), .channel_fault_out_o(),
      .channel_fault_out_oe_o(), .fault_detect_o(fdet));
   // fault-pin variant fed by a controller that grounds the kind select
   dsdm_mcu_model #(.FAULT_PIN_VARIANT(1)) mcu_f_u (.clk_i(clk_i),
      .cmd_i(cmd), .pins_o(pins_f));
   dsdm_switch_ctrl #(.FAULT_PIN_VARIANT(1), .STBY_CYCLES(8),
      .RETRY_CYCLES(16)) dut_f_u (
      .clk_i(clk_i), .reset_i(reset_i), .ch1_switch_on_i(pins_f[4]),
      .ch2_switch_on_i(pins_f[3]), .diag_enable_i(pins_f[2]),
      .sense_kind_select_i(pins_f[1]), .sense_channel_select_i(pins_f[0]),
      .latch_i(latch), .overtemp_i(ot), .overcurrent_i(oc),
      .openload_i(ol), .out_near_supply_i(ns), .ch1_hotter_i(hot1),
      .gate_on_o(), .mode_o(), .sense_kind_o(kind_f),
      .sense_out_oe_o(), .fault_sense_level_o(),
      .temp_from_ch2_o(), .channel_fault_out_o(fpin_f),
      .channel_fault_out_oe_o(fpin_oe_f), .fault_detect_o());
   // compare one value and count it
   task automatic check(input string nm, input logic [2:0] s, e);
      compares = compares + 1;
      if (s !== e)
      begin
         num_errors = num_errors + 1;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic stop_test;
      if (num_errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wt(input integer n);
      repeat (n) @(negedge clk_i);
   endtask
   // expected sense source from command and per-channel fault flags
   function automatic logic [2:0] exp_kind(input logic [4:0] c,
                                           input logic [1:0] f);
      if (!c[2] || c[1:0] == 2'h3) return 3'h4;
      if (c[1]) return 3'h2;
      return f[c[0]] ? 3'h3 : {2'h0, c[0]};
   endfunction
   // median of three sense samples, filtered here in the bench
   function automatic logic [2:0] med3(input logic [2:0] a, b, c);
      if ((a <= b && b <= c) || (c <= b && b <= a)) return b;
      if ((b <= a && a <= c) || (c <= a && a <= b)) return a;
      return c;
   endfunction
   initial
   begin
      wt(2);
      reset_i <= 1'b0;
      check("mode", mode, 3'h0);
      check("kind", kind, 3'h4);
      // diagnostic state, every select code
      for (i = 0; i < 4; i = i + 1)
      begin
         cmd <= {3'h1, i[1:0]};
         wt(7);
         check("kind", kind, exp_kind(cmd, 2'h0));
         check("oe", {2'h0, oe}, {2'h0, exp_kind(cmd, 2'h0) != 3'h4});
         check("mode", mode, 3'h2);
      end
      // off-state open load on ch2 while ch1 runs
      ol <= 2'h3;
      cmd <= 5'h15;
      hot1 <= 1'b1;
      wt(7);
      check("fdet", {1'b0, fdet}, 3'h2);
      check("kind", kind, 3'h3);
      check("fsl", {2'h0, fsl}, 3'h1);
      check("mode", mode, 3'h3);
      check("fpin_oe", {1'b0, fpin_oe_f}, 3'h2);
      check("fpin", {1'b0, fpin_f}, 3'h0);
      check("kind_f", kind_f, 3'h3);
      cmd <= 5'h14;
      wt(7);
      check("kind", kind, 3'h0);
      check("kind_f", kind_f, 3'h0);
      check("fpin_oe", {1'b0, fpin_oe_f}, 3'h2);
      cmd <= 5'h16;
      hot1 <= 1'b0;
      wt(7);
      check("kind", kind, 3'h2);
      check("kind_f", kind_f, 3'h0);
      check("t2", {2'h0, t2}, 3'h1);
      cmd <= 5'h1c;
      wt(7);
      check("fdet", {1'b0, fdet}, 3'h0);
      ol <= 2'h0;
      // latched overcurrent on ch1, then retry
      latch <= 1'b1;
      oc <= 2'h1;
      wt(1);
      oc <= 2'h0;
      wt(2);
      check("gate", {1'b0, gate}, 3'h2);
      check("kind", kind, 3'h3);
      check("fpin_oe", {1'b0, fpin_oe_f}, 3'h1);
      wt(30);
      check("gate", {1'b0, gate}, 3'h2);
      latch <= 1'b0;
      wt(25);
      check("gate", {1'b0, gate}, 3'h3);
      check("kind", kind, 3'h3);
      ns <= 2'h1;
      wt(3);
      check("kind", kind, 3'h0);
      // overtemperature with enable dropped stays off after retry
      ot <= 2'h1;
      ns <= 2'h0;
      wt(1);
      ot <= 2'h0;
      cmd <= 5'h0c;
      wt(30);
      check("gate", {1'b0, gate}, 3'h2);
      // all low: standby delay, then standby
      cmd <= 5'h00;
      wt(5);
      check("mode", mode, 3'h0);
      wt(12);
      check("mode", mode, 3'h1);
      check("kind", kind, 3'h4);
      check("fpin_oe", {1'b0, fpin_oe_f}, 3'h0);
      // random selects and enables with ch1 running
      for (i = 0; i < 40; i = i + 1)
      begin
         r = $random(seed);
         cmd <= {1'b1, r[3:0]};
         wt(6);
         k0 = kind;
         wt(1);
         k1 = kind;
         wt(1);
         check("kind", med3(k0, k1, kind), exp_kind(cmd, 2'h0));
      end
      stop_test();
   end
   // watchdog against a hang
   initial
   begin
      #200000;
      num_errors = num_errors + 1;
      stop_test();
   end
endmodule
`default_nettype wire
